// file: rtl/etd_pkg.sv
package etd_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_LO_CTRL = 8'h00;
    localparam logic [7:0] ADDR_LO_CMP  = 8'h04;
    localparam logic [7:0] ADDR_HI_CTRL = 8'h08;
    localparam logic [7:0] ADDR_HI_CMP  = 8'h0c;
    localparam logic [7:0] ADDR_STATUS  = 8'h10;
    localparam logic [7:0] ADDR_MISC    = 8'h14;

    // ------------------------------------------------------------
    // Control and misc register fields
    // ------------------------------------------------------------
    localparam int CK_LSB   = 4;
    localparam int MODE_LSB = 0;
    localparam int START_B  = 3;
    localparam int TFF_B    = 7;
    localparam int PRE_SRC_B = 0;
    localparam int LOWSPD_B  = 1;

    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CMP_RST  = 8'hff;

    // Mode field codes
    localparam logic [2:0] MODE_TIMER = 3'h0;
    localparam logic [2:0] MODE_PDO   = 3'h1;
    localparam logic [2:0] MODE_LO16  = 3'h3;
    localparam logic [2:0] MODE_T16   = 3'h4;

    // Clock select codes
    localparam logic [2:0] CK_DIV11 = 3'h0;
    localparam logic [2:0] CK_DIV7  = 3'h1;
    localparam logic [2:0] CK_DIV5  = 3'h2;
    localparam logic [2:0] CK_DIV3  = 3'h3;
    localparam logic [2:0] CK_PIN   = 3'h7;

    // Prescaler taps: fc/2^n, fs/2^3
    localparam int PRE_W   = 11;
    localparam int TAP_11  = 10;
    localparam int TAP_7   = 6;
    localparam int TAP_5   = 4;
    localparam int TAP_3   = 2;
    localparam int FS_DIV_DEF = 8;

    localparam logic [7:0] ONE8 = 8'h01;
endpackage

// file: rtl/etd_counter.sv
module etd_counter
    import etd_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       run_in,
    input  wire logic       tick_in,
    input  wire logic [7:0] cmp_in,
    output logic [7:0]      count_out,
    output logic            match_out
);
    logic [7:0] next_count;
    logic       hit;

    always_comb begin
        hit        = run_in && tick_in && (count_out == cmp_in);
        next_count = count_out;
        if (!run_in) begin
            next_count = 8'h00;
        end else if (hit) begin
            next_count = 8'h00;
        end else if (tick_in) begin
            next_count = count_out + ONE8;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            count_out <= 8'h00;
            match_out <= 1'b0;
        end else begin
            count_out <= next_count;
            match_out <= hit;
        end
    end
endmodule

// file: rtl/etd_timer.sv
module etd_timer
    import etd_pkg::*;
#(
    parameter int FS_DIV = FS_DIV_DEF
)(
    input  wire logic        CLK_IN,
    input  wire logic        SYS_RST_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    input  wire logic        EVENT_INPUT_PIN_IN,
    output logic [31:0]      PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    output logic             LO_MATCH_IRQ_OUT,
    output logic             HI_MATCH_IRQ_OUT,
    output logic             DIVIDER_OUT_PIN_OUT
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ETD_IDLE = 2'b00,
        ETD_DONE = 2'b01
    } etd_bus_e;

    etd_bus_e    bus_st, next_bus_st;
    logic [7:0]  lo_ctrl, next_lo_ctrl;
    logic [7:0]  hi_ctrl, next_hi_ctrl;
    logic [7:0]  lo_cmp, next_lo_cmp;
    logic [7:0]  hi_cmp, next_hi_cmp;
    logic [1:0]  misc, next_misc;
    logic        tff, next_tff;
    logic [31:0] next_prdata;
    logic        next_slverr;

    logic [PRE_W-1:0] pre, next_pre;
    logic [PRE_W-1:0] pre_d;
    logic [3:0]       fs_cnt, next_fs_cnt;
    logic [2:0]       fs_pre, next_fs_pre;
    logic             fs_tick;
    logic             ev_d1, ev_d2;

    logic [7:0] lo_count, hi_count;
    logic       lo_match, hi_match;
    logic       lo_tick, hi_tick;
    logic       lo_run, hi_run;
    logic       cascade;
    logic       fs_div8_rise;

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function automatic logic tap_rise(input logic [PRE_W-1:0] p,
                                      input logic [PRE_W-1:0] pd,
                                      input int             b);
        return p[b] && !pd[b];
    endfunction

    function automatic logic sel_tick(input logic [2:0] ck,
                                      input logic pre_src,
                                      input logic low_spd,
                                      input logic fsr,
                                      input logic [PRE_W-1:0] p,
                                      input logic [PRE_W-1:0] pd);
        logic t;
        t = 1'b0;
        if (low_spd) begin
            t = (ck == CK_DIV11) ? fsr : 1'b0;
        end else begin
            unique case (ck)
                CK_DIV11: t = pre_src ? fsr : tap_rise(p, pd, TAP_11);
                CK_DIV7:  t = tap_rise(p, pd, TAP_7);
                CK_DIV5:  t = tap_rise(p, pd, TAP_5);
                CK_DIV3:  t = tap_rise(p, pd, TAP_3);
                default:  t = 1'b0;
            endcase
        end
        return t;
    endfunction

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    always_comb begin
        next_pre    = pre + {{(PRE_W-1){1'b0}}, 1'b1};
        next_fs_cnt = fs_cnt;
        next_fs_pre = fs_pre;
        fs_tick     = 1'b0;
        if (fs_cnt == 4'(FS_DIV - 1)) begin
            next_fs_cnt = 4'h0;
            next_fs_pre = fs_pre + 3'h1;
            fs_tick     = (fs_pre == 3'h7);
        end else begin
            next_fs_cnt = fs_cnt + 4'h1;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            pre    <= '0;
            pre_d  <= '0;
            fs_cnt <= 4'h0;
            fs_pre <= 3'h0;
            fs_div8_rise <= 1'b0;
            ev_d1  <= 1'b1;
            ev_d2  <= 1'b1;
        end else begin
            pre    <= next_pre;
            pre_d  <= pre;
            fs_cnt <= next_fs_cnt;
            fs_pre <= next_fs_pre;
            fs_div8_rise <= fs_tick;
            ev_d1  <= EVENT_INPUT_PIN_IN;
            ev_d2  <= ev_d1;
        end
    end

    // ------------------------------------------------------------
    // Counter clocking and cascade
    // ------------------------------------------------------------
    always_comb begin
        cascade = hi_ctrl[MODE_LSB+2] &&
                  (lo_ctrl[MODE_LSB+:3] == MODE_LO16);
        lo_run  = cascade ? hi_ctrl[START_B] : lo_ctrl[START_B];
        hi_run  = hi_ctrl[START_B];
        // cascaded source from lower counter select
        lo_tick = sel_tick(lo_ctrl[CK_LSB+:3], misc[PRE_SRC_B],
                           misc[LOWSPD_B], fs_div8_rise, pre, pre_d);
        if (cascade) begin
            // lower counter runs up to 0xff then overflows
            hi_tick = lo_tick && (lo_count == 8'hff);
        end else if (hi_ctrl[CK_LSB+:3] == CK_PIN) begin
            // falling edge of synchronised event pin
            // event counting only on upper counter
            hi_tick = ev_d2 && !ev_d1;
        end else begin
            hi_tick = sel_tick(hi_ctrl[CK_LSB+:3], misc[PRE_SRC_B],
                               misc[LOWSPD_B], fs_div8_rise, pre, pre_d);
        end
    end

    etd_counter u_lo (
        .clk_in    (CLK_IN),
        .rst_in    (SYS_RST_IN),
        .run_in    (lo_run),
        .tick_in   (lo_tick),
        .cmp_in    (cascade ? 8'hff : lo_cmp),
        .count_out (lo_count),
        .match_out (lo_match)
    );

    etd_counter u_hi (
        .clk_in    (CLK_IN),
        .rst_in    (SYS_RST_IN),
        .run_in    (hi_run),
        .tick_in   (hi_tick),
        .cmp_in    (hi_cmp),
        .count_out (hi_count),
        .match_out (hi_match)
    );

    // ------------------------------------------------------------
    // Output flip-flop
    // ------------------------------------------------------------
    always_comb begin
        next_tff = tff;
        if (!hi_run) begin
            // loadable while stopped via initial bit
            next_tff = hi_ctrl[TFF_B];
        end else if (hi_match &&
                     hi_ctrl[MODE_LSB+:3] == MODE_PDO) begin
            // equal half periods give 50 percent duty
            next_tff = !tff;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            tff                 <= 1'b0;
            DIVIDER_OUT_PIN_OUT <= 1'b1;
            LO_MATCH_IRQ_OUT    <= 1'b0;
            HI_MATCH_IRQ_OUT    <= 1'b0;
        end else begin
            tff <= next_tff;
            DIVIDER_OUT_PIN_OUT <= !next_tff;
            LO_MATCH_IRQ_OUT    <= lo_match && !cascade;
            HI_MATCH_IRQ_OUT    <= hi_match;
        end
    end

    // ------------------------------------------------------------
    // APB slave, one wait state
    // ------------------------------------------------------------
    always_comb begin
        next_bus_st  = ETD_IDLE;
        next_lo_ctrl = lo_ctrl;
        next_hi_ctrl = hi_ctrl;
        next_lo_cmp  = lo_cmp;
        next_hi_cmp  = hi_cmp;
        next_misc    = misc;
        next_prdata  = 32'h0000_0000;
        next_slverr  = 1'b0;
        if (PSEL_IN && PENABLE_IN && bus_st == ETD_IDLE) begin
            next_bus_st = ETD_DONE;
            unique case (PADDR_IN)
                ADDR_LO_CTRL: next_prdata = {24'h0, lo_ctrl};
                ADDR_LO_CMP:  next_prdata = {24'h0, lo_cmp};
                ADDR_HI_CTRL: next_prdata = {24'h0, hi_ctrl};
                ADDR_HI_CMP:  next_prdata = {24'h0, hi_cmp};
                ADDR_STATUS:  next_prdata = {15'h0, tff,
                                             hi_count, lo_count};
                ADDR_MISC:    next_prdata = {30'h0, misc};
                default:      next_slverr = 1'b1;
            endcase
            if (PWRITE_IN) begin
                next_prdata = 32'h0000_0000;
                unique case (PADDR_IN)
                    ADDR_LO_CTRL: next_lo_ctrl = PWDATA_IN[7:0];
                    ADDR_LO_CMP:  next_lo_cmp  = PWDATA_IN[7:0];
                    ADDR_HI_CTRL: next_hi_ctrl = PWDATA_IN[7:0];
                    ADDR_HI_CMP:  next_hi_cmp  = PWDATA_IN[7:0];
                    ADDR_MISC:    next_misc    = PWDATA_IN[1:0];
                    default:      next_slverr  = 1'b1;
                endcase
                if (PADDR_IN == ADDR_STATUS) begin
                    next_slverr = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            bus_st      <= ETD_IDLE;
            lo_ctrl     <= CTRL_RST;
            hi_ctrl     <= CTRL_RST;
            lo_cmp      <= CMP_RST;
            hi_cmp      <= CMP_RST;
            misc        <= 2'b00;
            PRDATA_OUT  <= 32'h0000_0000;
            PREADY_OUT  <= 1'b0;
            PSLVERR_OUT <= 1'b0;
        end else begin
            bus_st      <= next_bus_st;
            lo_ctrl     <= next_lo_ctrl;
            hi_ctrl     <= next_hi_ctrl;
            lo_cmp      <= next_lo_cmp;
            hi_cmp      <= next_hi_cmp;
            misc        <= next_misc;
            PRDATA_OUT  <= next_prdata;
            PREADY_OUT  <= (next_bus_st == ETD_DONE);
            PSLVERR_OUT <= next_slverr;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (SYS_RST_IN);

    sequence s_hi_hit;
        hi_run && hi_tick && (hi_count == hi_cmp);
    endsequence

    // Two edges of pipeline between the hit and the pin
    sequence s_irq_pulse;
        HI_MATCH_IRQ_OUT ##1 !HI_MATCH_IRQ_OUT;
    endsequence

    chk_hi_clear: assert property (
        s_hi_hit |=> hi_count == 8'h00)
        else $error("upper counter not cleared on match");
    chk_hi_irq: assert property (
        s_hi_hit ##1 !(hi_run && hi_tick && hi_count == hi_cmp)
        |=> s_irq_pulse)
        else $error("match pulse wrong");
    chk_evt_count: assert property (
        (hi_run && !cascade && hi_ctrl[CK_LSB+:3] == CK_PIN
         && ev_d2 && !ev_d1 && hi_count != hi_cmp)
        |=> hi_count == $past(hi_count) + ONE8)
        else $error("event edge not counted");
    chk_no_tick: assert property (
        (hi_run && !hi_tick) |=> hi_count == $past(hi_count))
        else $error("count moved without tick");
    chk_pdo_toggle: assert property (
        (hi_run && hi_match && hi_ctrl[MODE_LSB+:3] == MODE_PDO
         && $stable(hi_ctrl)) |=> tff != $past(tff))
        else $error("flip-flop did not invert");
    chk_pin_inv: assert property (
        ##1 DIVIDER_OUT_PIN_OUT == !tff)
        else $error("divider pin not inverse");
    chk_tff_load: assert property (
        !hi_run |=> tff == $past(hi_ctrl[TFF_B]))
        else $error("flip-flop load failed");
    chk_cascade: assert property (
        (cascade && hi_run && lo_tick && lo_count == 8'hff
         && hi_count != hi_cmp)
        |=> hi_count == $past(hi_count) + ONE8)
        else $error("upper missed lower overflow");
    chk_stop_clr: assert property (
        !lo_run |=> lo_count == 8'h00)
        else $error("stopped counter not cleared");
    chk_lo_irq: assert property (
        (lo_match && !cascade) |=> LO_MATCH_IRQ_OUT)
        else $error("lower match pulse missing");
    chk_lo_quiet: assert property (
        cascade |=> !LO_MATCH_IRQ_OUT)
        else $error("lower pulse while cascaded");
endmodule

// file: test/etd_event_src.sv
module etd_event_src (
    input  wire logic       clk_in,
    input  wire logic       go_in,
    input  wire logic [7:0] pulses_in,
    output logic            pin_out,
    output logic            busy_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] left;
    logic [2:0] phase;
    initial begin
        pin_out = 1'b1;
        left = 8'h00;
        phase = 3'h0;
    end
    assign busy_out = (left != 8'h00);
    always @(posedge clk_in) begin
        if (go_in && left == 8'h00) begin
            left <= pulses_in;
            phase <= 3'h0;
        end else if (left != 8'h00) begin
            phase <= phase + 3'h1;
            pin_out <= (phase < 3'h4) ? 1'b0 : 1'b1;
            if (phase == 3'h7) begin
                left <= left - 8'h01;
            end
        end
    end
endmodule

// file: test/etd_timer_test.sv
module etd_timer_test
    import etd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIM = 10000;
    logic clk, rst, psel, pen, pwr, ev_go, ev_busy, rerr, lo_irq, hi_irq;
    logic pin, ev_pin, pready, perr;
    logic [7:0] paddr, ev_n;
    logic [31:0] pwdata, prdata, rdata;
    int fail_count, n_checks, h, l, w, i;
    etd_timer dut (.CLK_IN(clk), .SYS_RST_IN(rst), .PSEL_IN(psel),
        .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .EVENT_INPUT_PIN_IN(ev_pin),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(perr),
        .LO_MATCH_IRQ_OUT(lo_irq), .HI_MATCH_IRQ_OUT(hi_irq),
        .DIVIDER_OUT_PIN_OUT(pin));
    etd_event_src src (.clk_in(clk), .go_in(ev_go), .pulses_in(ev_n),
        .pin_out(ev_pin), .busy_out(ev_busy));
    // -----------------------------------------------
    // Shared tasks
    // -----------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic give_up;
        fail_count++;
        final_report();
    endtask
    // Request held until ready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            give_up();
        end
        rdata = prdata;
        rerr = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    function automatic logic sig(input int s);
        case (s)
            0: return lo_irq;
            1: return hi_irq;
            default: return pin;
        endcase
    endfunction
    // Length of a level; skip first waits for the next change
    task automatic run_len(input int s, input logic skip, output int n);
        logic v;
        int k;
        v = sig(s);
        for (k = 0; skip && k < LIM && sig(s) === v; k++) @(negedge clk);
        v = sig(s);
        for (n = 0; n < LIM && sig(s) === v; n++) @(negedge clk);
        if (n >= LIM || k >= LIM) begin
            give_up();
        end
    endtask
    task automatic pulses(input logic [7:0] n);
        int k;
        @(posedge clk);
        ev_go <= 1'b1;
        ev_n <= n;
        @(posedge clk);
        ev_go <= 1'b0;
        @(negedge clk);
        for (k = 0; k < LIM && ev_busy; k++) begin
            h += hi_irq;
            @(negedge clk);
        end
        if (k >= LIM) begin
            give_up();
        end
        repeat (8) @(negedge clk);
    endtask
    typedef struct {logic wr; logic [7:0] a; logic [31:0] d, rd;
                    logic err;} etd_row_s;
    etd_row_s rows[12] = '{
        '{0, ADDR_LO_CTRL, 0, 0, 0}, '{0, ADDR_LO_CMP, 0, 32'hff, 0},
        '{0, ADDR_HI_CTRL, 0, 0, 0}, '{0, ADDR_HI_CMP, 0, 32'hff, 0},
        '{0, ADDR_STATUS, 0, 0, 0}, '{0, ADDR_MISC, 0, 0, 0},
        '{1, ADDR_HI_CMP, 32'h5a, 0, 0}, '{0, ADDR_HI_CMP, 0, 32'h5a, 0},
        '{0, 8'h18, 0, 0, 1}, '{1, 8'h18, 32'h1, 0, 1},
        '{1, ADDR_STATUS, 32'h1, 0, 1}, '{1, ADDR_LO_CMP, 32'h1c3, 0, 0}};
    // Timer cases: misc, clock code, clocks per tick
    int tmr[6][3] = '{'{0, 3, 8}, '{0, 2, 32}, '{0, 1, 128},
                      '{0, 0, 2048}, '{1, 0, 64}, '{2, 0, 64}};
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        {rst, psel, pen, pwr, ev_go} = 5'h10;
        paddr = 8'h00;
        pwdata = 32'h0;
        ev_n = 8'h00;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check(pin, 1'b1);
        for (i = 0; i < 12; i++) begin
            apb(rows[i].wr, rows[i].a, rows[i].d);
            check(rdata, rows[i].rd);
            check(rerr, rows[i].err);
        end
        for (w = 0; w < 2; w++) begin
            for (i = 0; i < 6; i++) begin
                apb(1, ADDR_MISC, tmr[i][0]);
                apb(1, w ? ADDR_HI_CMP : ADDR_LO_CMP, 32'h2);
                apb(1, w ? ADDR_HI_CTRL : ADDR_LO_CTRL, tmr[i][1] * 16 + 8);
                run_len(w, 1, h);
                check(h, 1);
                run_len(w, 0, l);
                check(h + l, 3 * tmr[i][2]);
                // stop without touching the other fields
                apb(1, w ? ADDR_HI_CTRL : ADDR_LO_CTRL, tmr[i][1] * 16);
            end
        end
        apb(1, ADDR_MISC, 32'h0);
        // ---------------------------------------
        // Event counting on the upper counter
        // ---------------------------------------
        apb(1, ADDR_HI_CMP, 32'h3);
        apb(1, ADDR_HI_CTRL, 32'h78);
        h = 0;
        pulses(8'h2);
        apb(0, ADDR_STATUS, 32'h0);
        check(rdata[15:8], 8'h02);
        pulses(8'h6);
        check(h, 2);
        apb(0, ADDR_STATUS, 32'h0);
        check(rdata[15:8], 8'h00);
        // stop first, reprogram only while stopped
        apb(1, ADDR_HI_CTRL, 32'h70);
        // port latch sits outside; the pin is watched directly
        // ---------------------------------------
        // Divider output and flip-flop load
        // ---------------------------------------
        apb(1, ADDR_HI_CTRL, 32'h81);
        repeat (3) @(negedge clk);
        check(pin, 1'b0);
        apb(1, ADDR_HI_CTRL, 32'h01);
        repeat (3) @(negedge clk);
        check(pin, 1'b1);
        apb(1, ADDR_HI_CMP, 32'h4);
        apb(1, ADDR_HI_CTRL, 32'h39);
        run_len(2, 1, h);
        run_len(2, 0, l);
        check(h, 40);
        check(l, 40);
        apb(1, ADDR_HI_CTRL, 32'h31);
        // Upper's own clock field says pin; overflow must win
        apb(1, ADDR_HI_CMP, 32'h1);
        // cascaded source picked by the lower clock field
        apb(1, ADDR_LO_CTRL, 32'h3b);
        apb(1, ADDR_HI_CTRL, 32'h7c);
        run_len(1, 1, h);
        run_len(1, 0, l);
        check(h + l, 4096);
        // Two edges so no check attempt straddles the release
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        apb(0, ADDR_STATUS, 32'h0);
        check(rdata, 32'h0);
        check(pin, 1'b1);
        final_report();
    end
endmodule
